// ===== rtl/lbpd_top.sv
// Lock bit protection decoder: lock and fuse storage, programmer and CPU permission checks
// Overview of operation
// - Six lock bits; 1 means unprogrammed, 0 means programmed.
// - Only chip erase returns lock bits to 1; nothing else erases them.
// - Store instruction allowed over all flash only when self-program fuse reads 0.
// - Lock byte: memory bits 0-1, application 2-3, boot 4-5, 6-7 unused, default 1.
// - Memory lock mode 1 imposes no memory lock restriction.
// - Mode 2 refuses flash and EEPROM programming and locks the fuses.
// - Mode 3 also refuses verification and freezes the section lock bits.
// - Application mode 1: no store or load restriction on the application section.
// - Application mode 2: stores into the application section blocked, loads allowed.
// - Application mode 3: stores blocked, boot loads blocked, interrupts suppressed as stated.
// - Application mode 4: only boot loads blocked, same interrupt suppression.
// - Boot mode 1: no store or load restriction on the boot section.
// - Boot mode 2: stores into the boot section blocked.
// - Boot mode 3: stores blocked, application loads blocked, interrupts suppressed.
// - Boot mode 4: only application loads blocked, matching interrupt suppression.
// - Three fuse bytes; programmed fuse reads 0, unprogrammed reads 1.
// - Fuses latched on power-up and on programming entry and exit; preserve fuse acts at once.
module lbpd_top #(
	parameter logic [13:0] BOOT_START = lbpd_pkg::BOOT_START_RESET
) (
	input wire logic core_clk, // System clock, 50 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic prog_mode_pin, // Programming mode request pin, asynchronous
	input wire logic prog_req_valid, // Programmer command strobe
	input wire lbpd_pkg::lbpd_prog_req_s prog_req, // Programmer command
	output logic prog_mode_active, // Programming mode in force
	output logic prog_done, // Command carried out, pulse
	output logic prog_refused, // Command refused, pulse
	output logic [7:0] prog_rdata, // Read data for lock or fuse reads
	output logic prog_mem_write, // Granted flash or EEPROM write, pulse
	output logic prog_mem_read, // Granted flash or EEPROM verify read, pulse
	output logic prog_mem_eeprom, // Granted access targets EEPROM
	output logic chip_erase, // Chip erase strobe to the memories, pulse
	input wire logic cpu_req_valid, // CPU program memory access strobe
	input wire lbpd_pkg::lbpd_cpu_req_s cpu_req, // CPU access
	input wire logic cpu_vectors_in_boot, // Interrupt vectors sit in boot section
	output logic cpu_grant, // CPU access allowed, pulse
	output logic cpu_deny, // CPU access blocked, pulse
	output logic [7:0] cpu_rdata, // Lock byte for lock read
	output logic irq_suppress, // Interrupts disabled at current pc
	output logic [7:0] lock_byte, // Current lock bit byte
	output logic [23:0] fuse_latched, // Latched fuses, ext:high:low
	output logic eeprom_preserve_fuse, // EEPROM preserved through chip erase, active low
	output logic self_program_enable_fuse // Latched self-program fuse, active low
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	generate
		if (BOOT_START == 14'h0000) begin : g_bad_boot
			$error("BOOT_START must leave room for an application section");
		end
	endgenerate

	// ****************************************
	// Programming mode synchroniser
	// ****************************************
	logic prog_sync1_q;
	logic prog_sync2_q;
	logic prog_mode_q;
	logic init_done_q;
	logic fuse_latch_now;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prog_sync1_q <= 1'b0;
			prog_sync2_q <= 1'b0;
			prog_mode_q <= 1'b0;
		end else begin
			prog_sync1_q <= prog_mode_pin;
			prog_sync2_q <= prog_sync1_q;
			prog_mode_q <= prog_sync2_q;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			init_done_q <= 1'b0;
		end else begin
			init_done_q <= 1'b1;
		end
	end

	// Latch at power-up, on entering and on leaving programming mode
	assign fuse_latch_now = !init_done_q || (prog_sync2_q != prog_mode_q);

	// ****************************************
	// Lock decode
	// ****************************************
	logic [7:0] lock_q;
	logic prog_lock; // Flash, EEPROM and fuse programming frozen
	logic verify_lock; // Verification refused, section locks frozen
	logic app_store_block;
	logic app_load_block;
	logic boot_store_block;
	logic boot_load_block;

	// Mode 1 (11) leaves all flags clear
	assign prog_lock = lock_q[lbpd_pkg::MEM_LOCK_LOW_BIT] == 1'b0
		|| lock_q[lbpd_pkg::MEM_LOCK_HIGH_BIT] == 1'b0;
	assign verify_lock = lock_q[lbpd_pkg::MEM_LOCK_HIGH_BIT] == 1'b0;
	assign app_store_block = lock_q[lbpd_pkg::APP_LOCK_LOW_BIT] == 1'b0;
	assign app_load_block = lock_q[lbpd_pkg::APP_LOCK_HIGH_BIT] == 1'b0;
	assign boot_store_block = lock_q[lbpd_pkg::BOOT_LOCK_LOW_BIT] == 1'b0;
	assign boot_load_block = lock_q[lbpd_pkg::BOOT_LOCK_HIGH_BIT] == 1'b0;

	// Programming only clears bits; unused bits stay 1, frozen section bits unchanged
	function automatic logic [7:0] lbpd_program_lock(input logic [7:0] cur, input logic [7:0] req,
		input logic freeze_sections);
		logic [7:0] keep;
		keep = lbpd_pkg::LOCK_UNUSED_MASK;
		if (freeze_sections) begin
			keep = keep | lbpd_pkg::LOCK_SECTION_MASK;
		end
		return cur & (req | keep);
	endfunction

	// ****************************************
	// Programmer command decode
	// ****************************************
	logic prog_take;
	logic prog_ok;
	logic fuse_sel_ok;

	assign prog_take = prog_req_valid && prog_mode_q;
	assign fuse_sel_ok = prog_req.fuse_sel != 2'h3;

	always_comb begin
		prog_ok = 1'b0;
		unique case (prog_req.op)
			lbpd_pkg::prog_chip_erase: prog_ok = 1'b1;
			lbpd_pkg::prog_write_lock: prog_ok = 1'b1;
			lbpd_pkg::prog_read_lock: prog_ok = 1'b1;
			lbpd_pkg::prog_write_fuse: prog_ok = fuse_sel_ok && !prog_lock;
			lbpd_pkg::prog_read_fuse: prog_ok = fuse_sel_ok;
			lbpd_pkg::prog_write_flash: prog_ok = !prog_lock;
			lbpd_pkg::prog_write_eeprom: prog_ok = !prog_lock;
			lbpd_pkg::prog_read_flash: prog_ok = !verify_lock;
			lbpd_pkg::prog_read_eeprom: prog_ok = !verify_lock;
			default: prog_ok = 1'b0;
		endcase
	end

	// ****************************************
	// CPU access decode
	// ****************************************
	logic cpu_take;
	logic cpu_ok;
	logic target_boot;
	logic exec_boot;
	logic self_prog_ok;
	logic [7:0] fuse_lat_q [lbpd_pkg::FUSE_BYTES];

	// CPU is held off while the programmer owns the memories
	assign cpu_take = cpu_req_valid && !prog_mode_q;
	assign target_boot = cpu_req.target_addr >= BOOT_START;
	assign exec_boot = cpu_req.exec_pc >= BOOT_START;
	assign self_prog_ok = fuse_lat_q[lbpd_pkg::FUSE_SEL_EXT][lbpd_pkg::SELF_PROGRAM_FUSE_BIT] == 1'b0;

	always_comb begin
		cpu_ok = 1'b0;
		unique case (cpu_req.op)
			lbpd_pkg::cpu_store_program_memory_instr: begin
				cpu_ok = self_prog_ok && (target_boot ? !boot_store_block : !app_store_block);
			end
			lbpd_pkg::cpu_load_program_memory_instr: begin
				if (exec_boot && !target_boot) begin
					cpu_ok = !app_load_block;
				end else if (!exec_boot && target_boot) begin
					cpu_ok = !boot_load_block;
				end else begin
					cpu_ok = 1'b1;
				end
			end
			lbpd_pkg::cpu_lock_set: cpu_ok = self_prog_ok;
			lbpd_pkg::cpu_lock_read: cpu_ok = 1'b1;
			default: cpu_ok = 1'b0;
		endcase
	end

	// ****************************************
	// Lock bit storage
	// ****************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lock_q <= lbpd_pkg::LOCK_RESET;
		end else if (prog_take && prog_req.op == lbpd_pkg::prog_chip_erase) begin
			lock_q <= lbpd_pkg::LOCK_RESET;
		end else if (prog_take && prog_req.op == lbpd_pkg::prog_write_lock) begin
			lock_q <= lbpd_program_lock(lock_q, prog_req.data, verify_lock);
		end else if (cpu_take && cpu_ok && cpu_req.op == lbpd_pkg::cpu_lock_set) begin
			lock_q <= lbpd_program_lock(lock_q, cpu_req.data, verify_lock);
		end
	end

	// ****************************************
	// Fuse storage and latching
	// ****************************************
	logic [7:0] fuse_nv_q [lbpd_pkg::FUSE_BYTES];

	generate
		for (genvar i = 0; i < lbpd_pkg::FUSE_BYTES; i++) begin : g_fuse
			localparam logic [1:0] SEL = 2'(i);
			localparam logic [7:0] RST_VAL = (i == 0) ? lbpd_pkg::FUSE_LOW_RESET :
				(i == 1) ? lbpd_pkg::FUSE_HIGH_RESET : lbpd_pkg::FUSE_EXT_RESET;

			// Stored polarity is the read polarity: 0 programmed
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					fuse_nv_q[i] <= RST_VAL;
				end else if (prog_take && prog_ok && prog_req.op == lbpd_pkg::prog_write_fuse
					&& prog_req.fuse_sel == SEL) begin
					fuse_nv_q[i] <= prog_req.data;
				end
			end

			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					fuse_lat_q[i] <= RST_VAL;
				end else if (fuse_latch_now) begin
					fuse_lat_q[i] <= fuse_nv_q[i];
				end
			end

			assign fuse_latched[8 * i +: 8] = fuse_lat_q[i];
		end
	endgenerate

	// ****************************************
	// Programmer answers
	// ****************************************
	logic prog_done_q;
	logic prog_refused_q;
	logic [7:0] prog_rdata_q;
	logic prog_mem_write_q;
	logic prog_mem_read_q;
	logic prog_mem_eeprom_q;
	logic chip_erase_q;
	logic is_eeprom_op;

	assign is_eeprom_op = prog_req.op == lbpd_pkg::prog_write_eeprom || prog_req.op == lbpd_pkg::prog_read_eeprom;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prog_done_q <= 1'b0;
			prog_refused_q <= 1'b0;
			prog_mem_write_q <= 1'b0;
			prog_mem_read_q <= 1'b0;
			prog_mem_eeprom_q <= 1'b0;
			chip_erase_q <= 1'b0;
		end else begin
			prog_done_q <= prog_take && prog_ok;
			prog_refused_q <= prog_take && !prog_ok;
			prog_mem_write_q <= prog_take && prog_ok
				&& (prog_req.op == lbpd_pkg::prog_write_flash || prog_req.op == lbpd_pkg::prog_write_eeprom);
			prog_mem_read_q <= prog_take && prog_ok
				&& (prog_req.op == lbpd_pkg::prog_read_flash || prog_req.op == lbpd_pkg::prog_read_eeprom);
			prog_mem_eeprom_q <= prog_take && prog_ok && is_eeprom_op;
			chip_erase_q <= prog_take && prog_req.op == lbpd_pkg::prog_chip_erase;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prog_rdata_q <= 8'h00;
		end else if (prog_take && prog_ok && prog_req.op == lbpd_pkg::prog_read_lock) begin
			prog_rdata_q <= lock_q;
		end else if (prog_take && prog_ok && prog_req.op == lbpd_pkg::prog_read_fuse) begin
			prog_rdata_q <= fuse_nv_q[prog_req.fuse_sel];
		end
	end

	// ****************************************
	// CPU answers and interrupt suppression
	// ****************************************
	logic cpu_grant_q;
	logic cpu_deny_q;
	logic [7:0] cpu_rdata_q;
	logic irq_suppress_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cpu_grant_q <= 1'b0;
			cpu_deny_q <= 1'b0;
		end else begin
			cpu_grant_q <= cpu_req_valid && cpu_take && cpu_ok;
			cpu_deny_q <= cpu_req_valid && !(cpu_take && cpu_ok);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cpu_rdata_q <= 8'h00;
		end else if (cpu_take && cpu_req.op == lbpd_pkg::cpu_lock_read) begin
			cpu_rdata_q <= lock_q;
		end
	end

	// Follows the pc presented on the CPU port every cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_suppress_q <= 1'b0;
		end else begin
			irq_suppress_q <= (!exec_boot && cpu_vectors_in_boot && app_load_block)
				|| (exec_boot && !cpu_vectors_in_boot && boot_load_block);
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	logic prog_active_q;
	logic [7:0] lock_out_q;
	logic eeprom_preserve_q;
	logic self_prog_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prog_active_q <= 1'b0;
			lock_out_q <= lbpd_pkg::LOCK_RESET;
			eeprom_preserve_q <= 1'b1;
			self_prog_q <= 1'b1;
		end else begin
			prog_active_q <= prog_mode_q;
			lock_out_q <= lock_q;
			// Stored value, not the latched copy, so it acts at once
			eeprom_preserve_q <= fuse_nv_q[lbpd_pkg::FUSE_SEL_HIGH][lbpd_pkg::EEPROM_PRESERVE_FUSE_BIT];
			self_prog_q <= fuse_lat_q[lbpd_pkg::FUSE_SEL_EXT][lbpd_pkg::SELF_PROGRAM_FUSE_BIT];
		end
	end

	assign prog_mode_active = prog_active_q;
	assign prog_done = prog_done_q;
	assign prog_refused = prog_refused_q;
	assign prog_rdata = prog_rdata_q;
	assign prog_mem_write = prog_mem_write_q;
	assign prog_mem_read = prog_mem_read_q;
	assign prog_mem_eeprom = prog_mem_eeprom_q;
	assign chip_erase = chip_erase_q;
	assign cpu_grant = cpu_grant_q;
	assign cpu_deny = cpu_deny_q;
	assign cpu_rdata = cpu_rdata_q;
	assign irq_suppress = irq_suppress_q;
	assign lock_byte = lock_out_q;
	assign eeprom_preserve_fuse = eeprom_preserve_q;
	assign self_program_enable_fuse = self_prog_q;

endmodule

// ===== rtl/lbpd_pkg.sv
// Constants and carrier types for the lock bit protection decoder
package lbpd_pkg;

	// ****************************************
	// Lock bit byte layout
	// ****************************************
	localparam int LOCK_W = 8;
	localparam int MEM_LOCK_LOW_BIT = 0;
	localparam int MEM_LOCK_HIGH_BIT = 1;
	localparam int APP_LOCK_LOW_BIT = 2;
	localparam int APP_LOCK_HIGH_BIT = 3;
	localparam int BOOT_LOCK_LOW_BIT = 4;
	localparam int BOOT_LOCK_HIGH_BIT = 5;
	localparam logic [7:0] LOCK_UNUSED_MASK = 8'hc0;
	localparam logic [7:0] LOCK_SECTION_MASK = 8'h3c;
	localparam logic [7:0] LOCK_RESET = 8'hff;

	// ****************************************
	// Fuse bytes
	// ****************************************
	localparam int FUSE_BYTES = 3;
	localparam logic [1:0] FUSE_SEL_LOW = 2'h0;
	localparam logic [1:0] FUSE_SEL_HIGH = 2'h1;
	localparam logic [1:0] FUSE_SEL_EXT = 2'h2;
	localparam logic [7:0] FUSE_LOW_RESET = 8'h62;
	localparam logic [7:0] FUSE_HIGH_RESET = 8'hd9;
	localparam logic [7:0] FUSE_EXT_RESET = 8'hff;
	localparam int EEPROM_PRESERVE_FUSE_BIT = 3;
	localparam int SELF_PROGRAM_FUSE_BIT = 3;

	// ****************************************
	// Flash map
	// ****************************************
	localparam int PC_W = 14;
	localparam logic [13:0] BOOT_START_RESET = 14'h3800;

	// ****************************************
	// Programmer commands and CPU operations
	// ****************************************
	typedef enum logic [3:0] {
		prog_chip_erase,
		prog_write_lock,
		prog_read_lock,
		prog_write_fuse,
		prog_read_fuse,
		prog_write_flash,
		prog_read_flash,
		prog_write_eeprom,
		prog_read_eeprom
	} lbpd_prog_op_e;

	typedef enum logic [1:0] {
		cpu_load_program_memory_instr,
		cpu_store_program_memory_instr,
		cpu_lock_set,
		cpu_lock_read
	} lbpd_cpu_op_e;

	typedef struct packed {
		lbpd_prog_op_e op;
		logic [1:0] fuse_sel;
		logic [7:0] data;
	} lbpd_prog_req_s;

	typedef struct packed {
		lbpd_cpu_op_e op;
		logic [13:0] exec_pc;
		logic [13:0] target_addr;
		logic [7:0] data;
	} lbpd_cpu_req_s;

endpackage

// ===== bench/lbpd_properties.sv
// Port checks for the lock bit protection decoder
module lbpd_properties #(
	parameter logic [13:0] BOOT_START = lbpd_pkg::BOOT_START_RESET
) (
	input wire logic core_clk, // Clock
	input wire logic rst, // Reset
	input wire logic prog_req_valid, // Command strobe
	input wire logic prog_done, // Done
	input wire logic prog_refused, // Refused
	input wire logic prog_mem_write, // Write grant
	input wire logic prog_mem_read, // Verify grant
	input wire logic chip_erase, // Erase
	input wire logic cpu_req_valid, // CPU strobe
	input wire lbpd_pkg::lbpd_cpu_req_s cpu_req, // CPU access
	input wire logic cpu_vectors_in_boot, // Vectors
	input wire logic cpu_grant, // Grant
	input wire logic cpu_deny, // Deny
	input wire logic irq_suppress, // Irq off
	input wire logic [7:0] lock_byte, // Locks
	input wire logic self_program_enable_fuse // Fuse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic st, ld, app_t, app_x, st_app, st_boot, ld_b2a, ld_a2b, irq_a, irq_b;
	assign st = cpu_req_valid && cpu_req.op == lbpd_pkg::cpu_store_program_memory_instr;
	assign ld = cpu_req_valid && cpu_req.op == lbpd_pkg::cpu_load_program_memory_instr;
	assign app_t = cpu_req.target_addr < BOOT_START;
	assign app_x = cpu_req.exec_pc < BOOT_START;
	assign st_app = st && app_t;
	assign st_boot = st && !app_t;
	assign ld_b2a = ld && !app_x && app_t;
	assign ld_a2b = ld && app_x && !app_t;
	assign irq_a = app_x && cpu_vectors_in_boot;
	assign irq_b = !app_x && !cpu_vectors_in_boot;
	cpu_answer_a: assert property (cpu_req_valid |=> cpu_grant ^ cpu_deny) else $error("cpu answer");
	prog_answer_a: assert property ((prog_done || prog_refused) |-> $past(prog_req_valid)) else $error("prog answer");
	erase_sets_a: assert property (chip_erase |=> lock_byte == 8'hff) else $error("erase");
	erase_only_a: assert property ((lock_byte & ~$past(lock_byte)) != 8'h00 |-> $past(chip_erase))
		else $error("lock bit rose");
	unused_high_a: assert property (lock_byte[7:6] == 2'b11) else $error("unused bits");
	mem_write_a: assert property (prog_mem_write |-> lock_byte[1:0] == 2'b11) else $error("write grant");
	mem_verify_a: assert property (prog_mem_read |-> lock_byte[1]) else $error("verify grant");
	sect_frozen_a: assert property (lock_byte[1:0] == 2'b00 && !chip_erase |=> $stable(lock_byte[5:2]))
		else $error("sections moved");
	self_prog_a: assert property (cpu_grant && $past(st) |-> !self_program_enable_fuse) else $error("store");
	app_store_a: assert property (cpu_grant && $past(st_app) |-> lock_byte[2]) else $error("app store");
	boot_store_a: assert property (cpu_grant && $past(st_boot) |-> lock_byte[4]) else $error("boot store");
	app_load_a: assert property (cpu_grant && $past(ld_b2a) |-> lock_byte[3]) else $error("app load");
	boot_load_a: assert property (cpu_grant && $past(ld_a2b) |-> lock_byte[5]) else $error("boot load");
	irq_off_a: assert property (!$past(rst) |-> irq_suppress == ($past(irq_a) && !lock_byte[3]
		|| $past(irq_b) && !lock_byte[5])) else $error("irq");
endmodule
bind lbpd_top lbpd_properties #(.BOOT_START(BOOT_START)) chk (.core_clk(core_clk), .rst(rst),
	.prog_req_valid(prog_req_valid), .prog_done(prog_done), .prog_refused(prog_refused),
	.prog_mem_write(prog_mem_write), .prog_mem_read(prog_mem_read), .chip_erase(chip_erase),
	.cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req), .cpu_vectors_in_boot(cpu_vectors_in_boot),
	.cpu_grant(cpu_grant), .cpu_deny(cpu_deny), .irq_suppress(irq_suppress), .lock_byte(lock_byte),
	.self_program_enable_fuse(self_program_enable_fuse));

// ===== bench/lbpd_programmer.sv
// Programmer model: mode pin and command strobes
module lbpd_programmer (
	input wire logic core_clk, // Clock
	output logic prog_mode_pin, // Mode pin
	output logic prog_req_valid, // Command strobe
	output lbpd_pkg::lbpd_prog_req_s prog_req // Command
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		prog_mode_pin = 1'b0;
		prog_req_valid = 1'b0;
		prog_req = '0;
	end
	// Pin held past the synchroniser before any command
	task automatic mode(input logic on);
		@(posedge core_clk);
		prog_mode_pin <= on;
		repeat (5) @(posedge core_clk);
	endtask
	task automatic send(input lbpd_pkg::lbpd_prog_op_e op, input logic [1:0] sel, input logic [7:0] d);
		@(posedge core_clk);
		prog_req_valid <= 1'b1;
		prog_req <= '{op, sel, d};
	endtask
	task automatic idle();
		@(posedge core_clk);
		prog_req_valid <= 1'b0;
		prog_req <= ~prog_req;
	endtask
endmodule

// ===== bench/lock_bit_protection_decoder_bench.sv
// Self-checking bench for the lock bit protection decoder
module lock_bit_protection_decoder_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [13:0] BS = lbpd_pkg::BOOT_START_RESET;
	logic core_clk = 1'b0, rst = 1'b1, cpu_req_valid = 1'b0, cpu_vectors_in_boot = 1'b0;
	lbpd_pkg::lbpd_cpu_req_s cpu_req = '0;
	lbpd_pkg::lbpd_prog_req_s prog_req;
	logic prog_mode_pin, prog_req_valid, prog_done, prog_refused, prog_mem_write, prog_mem_read;
	logic prog_mem_eeprom, chip_erase, prog_mode_active, cpu_grant, cpu_deny, irq_suppress;
	logic eeprom_preserve_fuse, self_program_enable_fuse, sp;
	logic [7:0] prog_rdata, cpu_rdata, lock_byte, lk, prd, crd;
	logic [23:0] fuse_latched, fs;
	logic [13:0] pq[$], ap, bp;
	logic [9:0] cq[$];
	int fails = 0, tests_run = 0, seed = 83;
	always #10 core_clk = ~core_clk;
	lbpd_programmer PRG (.core_clk(core_clk), .prog_mode_pin(prog_mode_pin), .prog_req_valid(prog_req_valid),
		.prog_req(prog_req));
	lbpd_top #(.BOOT_START(BS)) DUT (.core_clk(core_clk), .rst(rst), .prog_mode_pin(prog_mode_pin),
		.prog_req_valid(prog_req_valid), .prog_req(prog_req), .prog_mode_active(prog_mode_active),
		.prog_done(prog_done), .prog_refused(prog_refused), .prog_rdata(prog_rdata), .prog_mem_write(prog_mem_write),
		.prog_mem_read(prog_mem_read), .prog_mem_eeprom(prog_mem_eeprom), .chip_erase(chip_erase),
		.cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req), .cpu_vectors_in_boot(cpu_vectors_in_boot),
		.cpu_grant(cpu_grant), .cpu_deny(cpu_deny), .cpu_rdata(cpu_rdata), .irq_suppress(irq_suppress),
		.lock_byte(lock_byte), .fuse_latched(fuse_latched), .eeprom_preserve_fuse(eeprom_preserve_fuse),
		.self_program_enable_fuse(self_program_enable_fuse));
	// ****************************************
	// Reference model and drivers
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic pcmd(input lbpd_pkg::lbpd_prog_op_e op, input logic [1:0] sel, input logic [7:0] d);
		logic ok, wr, rd, ee;
		ok = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		ee = op == lbpd_pkg::prog_write_eeprom || op == lbpd_pkg::prog_read_eeprom;
		case (op)
			lbpd_pkg::prog_chip_erase: lk = 8'hff;
			lbpd_pkg::prog_write_lock: lk = lk & (d | 8'hc0 | (lk[1] ? 8'h00 : 8'h3c));
			lbpd_pkg::prog_read_lock: prd = lk;
			lbpd_pkg::prog_write_fuse: begin
				ok = lk[1:0] == 2'b11 && sel != 2'h3;
				if (ok) fs[sel * 8 +: 8] = d;
			end
			lbpd_pkg::prog_read_fuse: begin
				ok = sel != 2'h3;
				if (ok) prd = fs[sel * 8 +: 8];
			end
			lbpd_pkg::prog_write_flash, lbpd_pkg::prog_write_eeprom: begin
				ok = lk[1:0] == 2'b11;
				wr = ok;
			end
			default: begin
				ok = lk[1];
				rd = ok;
			end
		endcase
		pq.push_back({ok, !ok, wr, rd, ee && (wr || rd), op == lbpd_pkg::prog_chip_erase, prd});
		PRG.send(op, sel, d);
	endtask
	task automatic ccmd(input lbpd_pkg::lbpd_cpu_op_e op, input logic [13:0] pc, ta, input logic [7:0] d);
		logic ok, pm;
		pm = prog_mode_pin;
		case (op)
			lbpd_pkg::cpu_store_program_memory_instr: ok = !sp && (ta >= BS ? lk[4] : lk[2]);
			lbpd_pkg::cpu_load_program_memory_instr: ok = (pc >= BS) == (ta >= BS) || (pc >= BS ? lk[3] : lk[5]);
			lbpd_pkg::cpu_lock_set: begin
				ok = !sp && !pm;
				if (ok) lk = lk & (d | 8'hc0 | (lk[1] ? 8'h00 : 8'h3c));
			end
			default: begin
				ok = 1'b1;
				if (!pm) crd = lk;
			end
		endcase
		ok = ok && !pm;
		cq.push_back({ok, !ok, crd});
		@(posedge core_clk);
		cpu_req_valid <= 1'b1;
		cpu_req <= '{op, pc, ta, d};
		cpu_vectors_in_boot <= 1'($random(seed));
	endtask
	task automatic cidle();
		@(posedge core_clk);
		cpu_req_valid <= 1'b0;
	endtask
	always @(negedge core_clk) begin
		if (prog_done === 1'b1 || prog_refused === 1'b1)
			check({prog_done, prog_refused, prog_mem_write, prog_mem_read, prog_mem_eeprom, chip_erase, prog_rdata},
				pq.size() ? pq.pop_front() : 14'h0, "prog answer");
		if (cpu_grant === 1'b1 || cpu_deny === 1'b1)
			check({cpu_grant, cpu_deny, cpu_rdata}, cq.size() ? cq.pop_front() : 10'h0, "cpu answer");
	end
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		finish_test();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		lk = 8'hff;
		prd = 8'h00;
		crd = 8'h00;
		fs = {lbpd_pkg::FUSE_EXT_RESET, lbpd_pkg::FUSE_HIGH_RESET, lbpd_pkg::FUSE_LOW_RESET};
		sp = 1'b1;
		repeat (5) @(posedge core_clk);
		check({self_program_enable_fuse, eeprom_preserve_fuse, lock_byte}, 10'h3ff, "reset");
		check(fuse_latched, fs, "fuse reset");
		rst <= 1'b0;
		ccmd(lbpd_pkg::cpu_store_program_memory_instr, 14'h0, 14'h0100, 8'h00);
		ccmd(lbpd_pkg::cpu_lock_read, 14'h0, 14'h0, 8'h00);
		cidle();
		PRG.mode(1'b1);
		ccmd(lbpd_pkg::cpu_lock_read, 14'h0, 14'h0, 8'h00);
		cidle();
		for (int s = 0; s < 4; s++)
			pcmd(lbpd_pkg::prog_read_fuse, 2'(s), 8'h00);
		pcmd(lbpd_pkg::prog_write_fuse, 2'h2, 8'hf7);
		pcmd(lbpd_pkg::prog_write_fuse, 2'h1, 8'hd1);
		PRG.idle();
		repeat (3) @(negedge core_clk);
		check(eeprom_preserve_fuse, 1'b0, "preserve fuse");
		check({prog_mode_active, fuse_latched}, {1'b1, 24'hffd962}, "latched early");
		for (int i = 5; i < 9; i++)
			pcmd(lbpd_pkg::lbpd_prog_op_e'(i), 2'h0, 8'($random(seed)));
		PRG.idle();
		PRG.mode(1'b0);
		sp = fs[19];
		check({self_program_enable_fuse, prog_mode_active, fuse_latched}, {2'b00, fs}, "latched on exit");
		for (int m = 0; m < 16; m++) begin
			PRG.mode(1'b1);
			pcmd(lbpd_pkg::prog_chip_erase, 2'h0, 8'h00);
			pcmd(lbpd_pkg::prog_write_lock, 2'h0, {2'b11, 4'(m), 2'b11});
			PRG.idle();
			PRG.mode(1'b0);
			ap = {1'b0, 13'($random(seed))};
			bp = BS | {3'b000, 11'($random(seed))};
			ccmd(lbpd_pkg::cpu_store_program_memory_instr, ap, ap, 8'h00);
			ccmd(lbpd_pkg::cpu_store_program_memory_instr, ap, bp, 8'h00);
			ccmd(lbpd_pkg::cpu_load_program_memory_instr, bp, ap, 8'h00);
			ccmd(lbpd_pkg::cpu_load_program_memory_instr, ap, bp, 8'h00);
			ccmd(lbpd_pkg::cpu_load_program_memory_instr, ap, ap, 8'h00);
			cidle();
			@(negedge core_clk);
			check(irq_suppress, cpu_vectors_in_boot && !lk[3], "irq off");
		end
		ccmd(lbpd_pkg::cpu_lock_set, 14'h0, 14'h0, 8'hef);
		ccmd(lbpd_pkg::cpu_store_program_memory_instr, 14'h0, BS, 8'h00);
		ccmd(lbpd_pkg::cpu_lock_read, 14'h0, 14'h0, 8'h00);
		cidle();
		PRG.mode(1'b1);
		pcmd(lbpd_pkg::prog_write_lock, 2'h0, 8'hfe);
		pcmd(lbpd_pkg::prog_write_flash, 2'h0, 8'h5a);
		pcmd(lbpd_pkg::prog_write_eeprom, 2'h0, 8'ha5);
		pcmd(lbpd_pkg::prog_read_flash, 2'h0, 8'h00);
		pcmd(lbpd_pkg::prog_write_fuse, 2'h0, 8'h00);
		pcmd(lbpd_pkg::prog_write_lock, 2'h0, 8'hfc);
		pcmd(lbpd_pkg::prog_read_eeprom, 2'h0, 8'h00);
		pcmd(lbpd_pkg::prog_write_lock, 2'h0, 8'hc3);
		pcmd(lbpd_pkg::prog_read_lock, 2'h0, 8'h00);
		pcmd(lbpd_pkg::prog_chip_erase, 2'h0, 8'h00);
		pcmd(lbpd_pkg::prog_read_lock, 2'h0, 8'h00);
		PRG.idle();
		repeat (4) @(negedge core_clk);
		check(pq.size() + cq.size(), 24'h0, "answers outstanding");
		finish_test();
	end
endmodule
